// *** shared/mbag_defines.vh ***
`ifndef MBAG_DEFINES_VH
`define MBAG_DEFINES_VH

// register offsets (byte addresses on the apb bus)
`define MBAG_OFS_CONTROL   12'h000
`define MBAG_OFS_BITREV    12'h004
`define MBAG_OFS_XSTART    12'h008
`define MBAG_OFS_XEND      12'h00c
`define MBAG_OFS_YSTART    12'h010
`define MBAG_OFS_YEND      12'h014
`define MBAG_OFS_STATUS    12'h018

// control register fields
`define MBAG_XSEL_HI       3
`define MBAG_XSEL_LO       0
`define MBAG_YSEL_HI       7
`define MBAG_YSEL_LO       4
`define MBAG_BSEL_HI       11
`define MBAG_BSEL_LO       8
`define MBAG_YMOD_EN_BIT   14
`define MBAG_XMOD_EN_BIT   15

// bit-reverse modifier register fields
`define MBAG_BITREV_ENABLE_BIT      15
`define MBAG_PIVOT_HI      14

// pointer select value that disables a feature
`define MBAG_SEL_OFF       4'hf

// reset values
`define MBAG_RST_CONTROL   16'h0000
`define MBAG_RST_BITREV    16'h0000
`define MBAG_RST_START     16'h0000
`define MBAG_RST_END       16'h0001

// addressing modes presented by the instruction decoder
`define MBAG_MODE_INDIRECT 3'h0
`define MBAG_MODE_POST_INC 3'h1
`define MBAG_MODE_POST_DEC 3'h2
`define MBAG_MODE_PRE_INC  3'h3
`define MBAG_MODE_PRE_DEC  3'h4
`define MBAG_MODE_REG_OFS  3'h5

`endif

// *** design/mbag_modulo_unit.v ***
`timescale 1ns/1ns
`include "mbag_defines.vh"

// one modulo corrector: wraps a raw address back into [start, end]
module mbag_modulo_unit #(
	parameter AW = 16
) (
	input  wire          enable,    // modulo active for this access
	input  wire          word_only, // force lsb clear (y space)
	input  wire [AW-1:0] buf_start, // lower boundary
	input  wire [AW-1:0] buf_end,   // upper boundary, last byte
	input  wire [AW-1:0] base,      // pointer before the change
	input  wire [AW-1:0] raw,       // pointer after the change
	output reg  [AW-1:0] corrected, // address after wrapping
	output reg           wrapped    // a boundary was crossed
);
	wire [AW-1:0] length;           // buffer size in bytes
	wire          pow2;             // length is a power of two
	wire          going_up;         // raw moved upwards
	wire          over;             // beyond the upper boundary
	wire          under;            // below the lower boundary

	assign length   = buf_end - buf_start + {{(AW-1){1'b0}}, 1'b1};
	assign pow2     = ((length & (length - {{(AW-1){1'b0}}, 1'b1})) == {AW{1'b0}});
	assign going_up = (raw >= base);
	// magnitude compare, so overshoots are still caught
	assign over     = (raw > buf_end);
	assign under    = (raw < buf_start);

	// a one-way buffer only checks the edge it travels towards
	always @* begin
		corrected = raw;
		wrapped   = 1'b0;
		if (enable) begin
			if (over && (going_up || pow2)) begin
				corrected = raw - length;
				wrapped   = 1'b1;
			end else if (under && (!going_up || pow2)) begin
				corrected = raw + length;
				wrapped   = 1'b1;
			end
		end
		if (word_only) begin
			corrected[0] = 1'b0;
		end
	end
endmodule

// *** design/mbag_addr_gen.v ***
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "mbag_defines.vh"

module mbag_addr_gen #(
	parameter AW = 16
) (
	input  wire          clock,
	input  wire          rstn,
	// apb slave
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [11:0]   paddr,
	input  wire [31:0]   pwdata,
	output wire          pready,
	output reg  [31:0]   prdata,
	output wire          pslverr,
	// x read generator request (data or program space)
	input  wire          xr_valid,
	input  wire [3:0]    xr_reg,
	input  wire [2:0]    xr_mode,
	input  wire [AW-1:0] xr_ptr,
	input  wire [AW-1:0] xr_offset,
	// x write generator request
	input  wire          xw_valid,
	input  wire [3:0]    xw_reg,
	input  wire [2:0]    xw_mode,
	input  wire          xw_byte,
	input  wire [AW-1:0] xw_ptr,
	input  wire [AW-1:0] xw_offset,
	// y generator request
	input  wire          y_valid,
	input  wire [3:0]    y_reg,
	input  wire [2:0]    y_mode,
	input  wire [AW-1:0] y_ptr,
	input  wire [AW-1:0] y_offset,
	// results, registered one cycle after the request
	output reg           xr_done,
	output reg  [AW-1:0] xr_addr,
	output reg           xr_wb,
	output reg  [AW-1:0] xr_wb_value,
	output reg           xw_done,
	output reg  [AW-1:0] xw_addr,
	output reg           xw_wb,
	output reg  [AW-1:0] xw_wb_value,
	output reg           y_done,
	output reg  [AW-1:0] y_addr,
	output reg           y_wb,
	output reg  [AW-1:0] y_wb_value
);
	// software visible registers
	reg  [15:0]   modulo_bitrev_control; // selects and enables
	reg  [15:0]   bitrev_modifier;       // enable and pivot
	reg  [AW-1:0] x_buffer_start;        // x lower boundary
	reg  [AW-1:0] x_buffer_end;          // x upper boundary
	reg  [AW-1:0] y_buffer_start;        // y lower boundary
	reg  [AW-1:0] y_buffer_end;          // y upper boundary
	reg  [2:0]    wrap_seen;             // sticky wrap flags, w1c

	// decoded control fields
	wire [3:0]    x_mod_pointer_select;
	wire [3:0]    y_mod_pointer_select;
	wire [3:0]    bitrev_pointer_select;
	wire          x_modulo_enable;
	wire          y_modulo_enable;
	wire          bitrev_enable;
	wire [14:0]   pivot_modifier;

	assign x_mod_pointer_select  = modulo_bitrev_control[`MBAG_XSEL_HI:`MBAG_XSEL_LO];
	assign y_mod_pointer_select  = modulo_bitrev_control[`MBAG_YSEL_HI:`MBAG_YSEL_LO];
	assign bitrev_pointer_select = modulo_bitrev_control[`MBAG_BSEL_HI:`MBAG_BSEL_LO];
	assign x_modulo_enable       = modulo_bitrev_control[`MBAG_XMOD_EN_BIT];
	assign y_modulo_enable       = modulo_bitrev_control[`MBAG_YMOD_EN_BIT];
	assign bitrev_enable         = bitrev_modifier[`MBAG_BITREV_ENABLE_BIT];
	assign pivot_modifier        = bitrev_modifier[`MBAG_PIVOT_HI:0];

	// modes that move the pointer and so write it back
	function is_modify;
		input [2:0] mode;
		begin
			is_modify = (mode == `MBAG_MODE_POST_INC) || (mode == `MBAG_MODE_POST_DEC) ||
				(mode == `MBAG_MODE_PRE_INC) || (mode == `MBAG_MODE_PRE_DEC);
		end
	endfunction

	// pre-modified modes address with the new pointer
	function is_pre;
		input [2:0] mode;
		begin
			is_pre = (mode == `MBAG_MODE_PRE_INC) || (mode == `MBAG_MODE_PRE_DEC);
		end
	endfunction

	// pointer after the mode's own change
	function [AW-1:0] moved;
		input [2:0]    mode;
		input [AW-1:0] ptr;
		input [AW-1:0] ofs;
		begin
			case (mode)
				`MBAG_MODE_POST_INC, `MBAG_MODE_PRE_INC, `MBAG_MODE_REG_OFS: begin
					moved = ptr + ofs;
				end
				`MBAG_MODE_POST_DEC, `MBAG_MODE_PRE_DEC: begin
					moved = ptr - ofs;
				end
				default: begin
					moved = ptr;
				end
			endcase
		end
	endfunction

	// modulo only on the selected pointer, select 15 is off
	function mod_hit;
		input       en;
		input [3:0] sel;
		input [3:0] wreg;
		begin
			mod_hit = en && (sel != `MBAG_SEL_OFF) && (sel == wreg);
		end
	endfunction

	// ---------------- apb slave ----------------
	wire apb_write;  // write takes effect this edge
	wire known_addr; // address decodes to a register

	assign pready    = 1'b1; // zero wait state
	assign apb_write = psel && penable && pwrite;
	assign known_addr = (paddr == `MBAG_OFS_CONTROL) || (paddr == `MBAG_OFS_BITREV) ||
		(paddr == `MBAG_OFS_XSTART) || (paddr == `MBAG_OFS_XEND) ||
		(paddr == `MBAG_OFS_YSTART) || (paddr == `MBAG_OFS_YEND) ||
		(paddr == `MBAG_OFS_STATUS);
	assign pslverr   = psel && penable && !known_addr;

	// read data is taken in the setup cycle, so it leaves a flip-flop
	// and still stands through the zero-wait access cycle; a wrap flag
	// set between setup and access shows on the next read only;
	// unmapped addresses read as zero with pslverr
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				`MBAG_OFS_CONTROL: prdata <= {16'h0000, modulo_bitrev_control};
				`MBAG_OFS_BITREV:  prdata <= {16'h0000, bitrev_modifier};
				`MBAG_OFS_XSTART:  prdata <= {16'h0000, x_buffer_start};
				`MBAG_OFS_XEND:    prdata <= {16'h0000, x_buffer_end};
				`MBAG_OFS_YSTART:  prdata <= {16'h0000, y_buffer_start};
				`MBAG_OFS_YEND:    prdata <= {16'h0000, y_buffer_end};
				`MBAG_OFS_STATUS:  prdata <= {29'h0000000, wrap_seen};
				default:           prdata <= 32'h00000000;
			endcase
		end
	end

	// register writes; boundaries keep their fixed low bit so
	// a start is always even and an end always odd
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			modulo_bitrev_control <= `MBAG_RST_CONTROL;
			bitrev_modifier       <= `MBAG_RST_BITREV;
			x_buffer_start        <= `MBAG_RST_START;
			x_buffer_end          <= `MBAG_RST_END;
			y_buffer_start        <= `MBAG_RST_START;
			y_buffer_end          <= `MBAG_RST_END;
		end else if (apb_write) begin
			case (paddr)
				`MBAG_OFS_CONTROL: modulo_bitrev_control <= pwdata[15:0];
				`MBAG_OFS_BITREV:  bitrev_modifier       <= pwdata[15:0];
				`MBAG_OFS_XSTART:  x_buffer_start        <= {pwdata[15:1], 1'b0};
				`MBAG_OFS_XEND:    x_buffer_end          <= {pwdata[15:1], 1'b1};
				`MBAG_OFS_YSTART:  y_buffer_start        <= {pwdata[15:1], 1'b0};
				`MBAG_OFS_YEND:    y_buffer_end          <= {pwdata[15:1], 1'b1};
				default: begin
				end
			endcase
		end
	end

	// ---------------- x read generator ----------------
	// serves data and program space alike, same pointer path
	wire          xr_mod_on;
	wire [AW-1:0] xr_raw;
	wire [AW-1:0] xr_fix;
	wire          xr_wrap;

	assign xr_mod_on = xr_valid && mod_hit(x_modulo_enable, x_mod_pointer_select, xr_reg);
	assign xr_raw    = moved(xr_mode, xr_ptr, xr_offset);

	mbag_modulo_unit #(.AW(AW)) u_xr_mod (
		.enable    (xr_mod_on),
		.word_only (1'b0),
		.buf_start (x_buffer_start),
		.buf_end   (x_buffer_end),
		.base      (xr_ptr),
		.raw       (xr_raw),
		.corrected (xr_fix),
		.wrapped   (xr_wrap)
	);

	// ---------------- x write generator ----------------
	wire          xw_rev_on;    // bit reversal this access
	wire          xw_mod_on;    // modulo this access
	wire [AW-1:0] pivot_bytes;  // pivot scaled to bytes
	wire [AW-1:0] xw_rev_next;  // reversed-carry sum
	wire [AW-1:0] xw_lin;
	wire [AW-1:0] xw_fix;
	wire          xw_wrap;
	wire [AW-1:0] xw_next;

	// reversal only for word writes with pre/post increment
	assign xw_rev_on = xw_valid && bitrev_enable && !xw_byte &&
		(bitrev_pointer_select != `MBAG_SEL_OFF) && (bitrev_pointer_select == xw_reg) &&
		((xw_mode == `MBAG_MODE_POST_INC) || (xw_mode == `MBAG_MODE_PRE_INC));
	// reversal has priority over modulo in this generator
	assign xw_mod_on = xw_valid && !xw_rev_on &&
		mod_hit(x_modulo_enable, x_mod_pointer_select, xw_reg);
	assign pivot_bytes = {pivot_modifier, 1'b0};
	assign xw_lin      = moved(xw_mode, xw_ptr, xw_offset);

	// add pointer and pivot with the carry running from msb
	// down to lsb; the pointer itself stays in normal order
	genvar gi;
	wire [AW:0] rcarry; // carry chain, rcarry[AW] enters at msb
	assign rcarry[AW] = 1'b0;
	generate
		for (gi = AW - 1; gi >= 1; gi = gi - 1) begin : g_rev
			assign xw_rev_next[gi] = xw_ptr[gi] ^ pivot_bytes[gi] ^ rcarry[gi+1];
			assign rcarry[gi]      = (xw_ptr[gi] & pivot_bytes[gi]) |
				(rcarry[gi+1] & (xw_ptr[gi] ^ pivot_bytes[gi]));
		end
	endgenerate
	assign rcarry[0]      = 1'b0;
	assign xw_rev_next[0] = 1'b0;

	mbag_modulo_unit #(.AW(AW)) u_xw_mod (
		.enable    (xw_mod_on),
		.word_only (1'b0),
		.buf_start (x_buffer_start),
		.buf_end   (x_buffer_end),
		.base      (xw_ptr),
		.raw       (xw_lin),
		.corrected (xw_fix),
		.wrapped   (xw_wrap)
	);

	assign xw_next = xw_rev_on ? xw_rev_next : xw_fix;

	// ---------------- y generator ----------------
	wire          y_mod_on;
	wire [AW-1:0] y_raw;
	wire [AW-1:0] y_fix;
	wire          y_wrap;
	wire [AW-1:0] y_old_ea; // old pointer as address, word aligned under modulo

	assign y_mod_on = y_valid && mod_hit(y_modulo_enable, y_mod_pointer_select, y_reg);
	assign y_raw    = moved(y_mode, y_ptr, y_offset);
	// post and plain indirect modes address with the old pointer,
	// which must be word aligned too while modulo is active
	assign y_old_ea = {y_ptr[AW-1:1], y_ptr[0] & ~y_mod_on};

	mbag_modulo_unit #(.AW(AW)) u_y_mod (
		.enable    (y_mod_on),
		.word_only (y_mod_on),
		.buf_start (y_buffer_start),
		.buf_end   (y_buffer_end),
		.base      (y_ptr),
		.raw       (y_raw),
		.corrected (y_fix),
		.wrapped   (y_wrap)
	);

	// ---------------- result registers ----------------
	// post modes address with the old pointer, pre and offset
	// modes with the corrected one; register offset never writes back
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			xr_done     <= 1'b0;
			xr_addr     <= {AW{1'b0}};
			xr_wb       <= 1'b0;
			xr_wb_value <= {AW{1'b0}};
			xw_done     <= 1'b0;
			xw_addr     <= {AW{1'b0}};
			xw_wb       <= 1'b0;
			xw_wb_value <= {AW{1'b0}};
			y_done      <= 1'b0;
			y_addr      <= {AW{1'b0}};
			y_wb        <= 1'b0;
			y_wb_value  <= {AW{1'b0}};
		end else begin
			xr_done     <= xr_valid;
			xr_wb       <= xr_valid && is_modify(xr_mode);
			xr_wb_value <= xr_fix;
			xr_addr     <= (is_pre(xr_mode) || xr_mode == `MBAG_MODE_REG_OFS) ? xr_fix : xr_ptr;
			xw_done     <= xw_valid;
			xw_wb       <= xw_valid && is_modify(xw_mode);
			xw_wb_value <= xw_next;
			xw_addr     <= (is_pre(xw_mode) || xw_mode == `MBAG_MODE_REG_OFS) ? xw_next : xw_ptr;
			y_done      <= y_valid;
			y_wb        <= y_valid && is_modify(y_mode);
			y_wb_value  <= y_fix;
			y_addr      <= (is_pre(y_mode) || y_mode == `MBAG_MODE_REG_OFS) ? y_fix : y_old_ea;
		end
	end

	// sticky wrap flags; a new wrap beats a clear in the same cycle
	wire [2:0] wrap_now;
	wire [2:0] wrap_clr;
	assign wrap_now = {y_wrap, xw_wrap, xr_wrap};
	assign wrap_clr = (apb_write && paddr == `MBAG_OFS_STATUS) ? pwdata[2:0] : 3'h0;

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wrap_seen <= 3'h0;
		end else begin
			wrap_seen <= (wrap_seen & ~wrap_clr) | wrap_now;
		end
	end
endmodule

// *** bench/mbag_monitor.sv ***
`timescale 1ns/1ns
`include "mbag_defines.vh"

// ties each generator result to the request one cycle earlier
module mbag_monitor #(
	parameter AW = 16
) (
	input wire          clock,
	input wire          rstn,
	input wire          psel,
	input wire          penable,
	input wire          pwrite,
	input wire [11:0]   paddr,
	input wire [31:0]   pwdata,
	input wire          pready,
	input wire          xr_valid,
	input wire [3:0]    xr_reg,
	input wire [2:0]    xr_mode,
	input wire [AW-1:0] xr_ptr,
	input wire [AW-1:0] xr_offset,
	input wire          xw_valid,
	input wire [3:0]    xw_reg,
	input wire [2:0]    xw_mode,
	input wire          xw_byte,
	input wire [AW-1:0] xw_ptr,
	input wire [AW-1:0] xw_offset,
	input wire          y_valid,
	input wire [3:0]    y_reg,
	input wire          xr_done,
	input wire [AW-1:0] xr_addr,
	input wire          xr_wb,
	input wire [AW-1:0] xr_wb_value,
	input wire          xw_wb,
	input wire [AW-1:0] xw_wb_value,
	input wire [AW-1:0] y_addr
);
	reg  [15:0] ctrl; // shadow of the control register
	reg  [15:0] brev; // shadow of the bit-reverse modifier
	wire        acc  = psel && penable && pwrite && pready;
	wire        x_on = ctrl[15] && ctrl[3:0] != 4'hf;
	wire        y_on = ctrl[14] && ctrl[7:4] != 4'hf;
	wire        b_on = brev[15] && ctrl[11:8] != 4'hf && xw_reg == ctrl[11:8];

	// shadows follow completed writes so conditions match the design's view
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl <= 16'h0000;
			brev <= 16'h0000;
		end else begin
			if (acc && paddr == `MBAG_OFS_CONTROL) ctrl <= pwdata[15:0];
			if (acc && paddr == `MBAG_OFS_BITREV) brev <= pwdata[15:0];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	chk_xr_latency: assert property (xr_valid |=> xr_done)
		else $error("x read result missing");
	chk_xr_spurious: assert property (!xr_valid |=> !xr_done)
		else $error("x read result without request");
	chk_wb_modify: assert property (xr_valid && xr_mode inside {[3'h1:3'h4]} |=> xr_wb)
		else $error("modify mode without write back");
	chk_wb_hold: assert property (xr_valid && xr_mode inside {3'h0, 3'h5} |=> !xr_wb)
		else $error("write back in a non modify mode");
	chk_y_word: assert property (y_valid && y_on && y_reg == ctrl[7:4] |=> !y_addr[0])
		else $error("y modulo address odd");
	chk_brev_word: assert property (
		xw_valid && b_on && !xw_byte && xw_mode inside {3'h1, 3'h3}
		|=> xw_wb && !xw_wb_value[0])
		else $error("reversed pointer odd or not written");
	chk_byte_plain: assert property (
		xw_valid && xw_byte && xw_mode == 3'h1 && !(x_on && xw_reg == ctrl[3:0])
		|=> xw_wb_value == $past(xw_ptr) + $past(xw_offset))
		else $error("byte write pointer not linear");
	chk_linear_read: assert property (
		xr_valid && xr_mode == 3'h1 && !(x_on && xr_reg == ctrl[3:0])
		|=> xr_addr == $past(xr_ptr) && xr_wb_value == $past(xr_ptr) + $past(xr_offset))
		else $error("linear read address wrong");
endmodule

bind mbag_addr_gen mbag_monitor #(.AW(AW)) mbag_monitor_i (.*);

// *** bench/test_mbag_addr_gen.sv ***
`timescale 1ns/1ns
`include "mbag_defines.vh"

`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
	$display("[FAIL] %0t got %h expected %h", $time, a, e); end end

// drivers queue expectations, the monitor process compares on each result
module test_mbag_addr_gen;
	localparam [2:0] IND = `MBAG_MODE_INDIRECT, PI = `MBAG_MODE_POST_INC;
	localparam [2:0] PD = `MBAG_MODE_POST_DEC, RI = `MBAG_MODE_PRE_INC;
	localparam [2:0] RD = `MBAG_MODE_PRE_DEC, RO = `MBAG_MODE_REG_OFS;
	logic        clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr, xr_valid = 0, xw_valid = 0, y_valid = 0, xw_byte = 0;
	logic [3:0]  xr_reg = 0, xw_reg = 0, y_reg = 0;
	logic [2:0]  xr_mode = 0, xw_mode = 0, y_mode = 0;
	logic [15:0] xr_ptr = 0, xr_offset = 0, xw_ptr = 0, xw_offset = 0, y_ptr = 0, y_offset = 0;
	logic        xr_done, xr_wb, xw_done, xw_wb, y_done, y_wb;
	logic [15:0] xr_addr, xr_wb_value, xw_addr, xw_wb_value, y_addr, y_wb_value;
	int          errors = 0, n_compared = 0;
	logic [32:0] qxr[$], qxw[$], qy[$]; // {wb, wb_value, addr}
	logic [33:0] aq[$];                // {write, slverr, data}

	mbag_addr_gen #(.AW(16)) mbag_addr_gen_i (.*);

	always #25 clock = ~clock;

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
	endfunction

	task finish_test;
		if (errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// write back value only matters when a write back is expected
	task chk(input logic [32:0] e, input logic [32:0] a);
		`CHK(a[15:0], e[15:0])
		`CHK(a[32], e[32])
		if (e[32] === 1'b1) `CHK(a[31:16], e[31:16])
	endtask

	// one apb transfer; held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
		int n;
		@(posedge clock);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1;
		aq.push_back({w, er, d});
		n = 0;
		do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
		psel <= 0; penable <= 0;
		if (n >= 20) begin errors++; $display("[FAIL] %0t apb hang", $time); finish_test; end
	endtask

	// one request on generator g (0 x read, 1 x write, 2 y); the other generators
	// go idle, and a repeated call on g keeps valid up for back to back requests
	task automatic rq(input int g, input logic [3:0] r, input logic [2:0] m,
		input logic [15:0] p, o, input logic b, input logic [15:0] ea, input logic wb,
		input logic [15:0] wv);
		@(posedge clock);
		xr_valid <= (g == 0);
		xw_valid <= (g == 1);
		y_valid  <= (g == 2);
		case (g)
			0: begin xr_reg <= r; xr_mode <= m; xr_ptr <= p; xr_offset <= o;
				qxr.push_back({wb, wv, ea}); end
			1: begin xw_reg <= r; xw_mode <= m; xw_ptr <= p; xw_offset <= o;
				xw_byte <= b; qxw.push_back({wb, wv, ea}); end
			default: begin y_reg <= r; y_mode <= m; y_ptr <= p; y_offset <= o;
				qy.push_back({wb, wv, ea}); end
		endcase
	endtask

	task idle;
		@(posedge clock);
		xr_valid <= 0; xw_valid <= 0; y_valid <= 0;
	endtask

	// an empty queue yields unknowns, so a stray result always mismatches
	always @(posedge clock) begin
		logic [33:0] e;
		if (xr_done === 1'b1) chk(qxr.size() ? qxr.pop_front() : 'x, {xr_wb, xr_wb_value, xr_addr});
		if (xw_done === 1'b1) chk(qxw.size() ? qxw.pop_front() : 'x, {xw_wb, xw_wb_value, xw_addr});
		if (y_done === 1'b1) chk(qy.size() ? qy.pop_front() : 'x, {y_wb, y_wb_value, y_addr});
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			e = aq.size() ? aq.pop_front() : 'x;
			`CHK(pslverr, e[32])
			if (e[33] !== 1'b1) `CHK(prdata, e[31:0])
		end
	end

	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		$display("[FAIL] %0t run hang", $time);
		finish_test;
	end

	initial begin
		int i;
		logic [31:0] s;
		repeat (10) @(posedge clock);
		rstn <= 1;
		for (i = 0; i < 7; i++) apb(0, 12'(i * 4), 32'(i == 3 || i == 5), 0);
		apb(0, 12'h01c, 0, 1);
		apb(1, 12'h01c, 32'h1, 1);
		s = 32'h4e19b8fe;
		for (i = 0; i < 24; i++) begin
			s = lfsr(s);
			rq(i % 3, s[3:0], PI, s[31:16], {12'h0, s[7:4]}, s[8], s[31:16], 1,
				s[31:16] + {12'h0, s[7:4]});
		end
		idle;
		apb(1, `MBAG_OFS_XSTART, 32'h0800, 0);
		apb(1, `MBAG_OFS_XEND, 32'h081f, 0);
		apb(1, `MBAG_OFS_CONTROL, 32'h80f2, 0);
		apb(0, `MBAG_OFS_CONTROL, 32'h80f2, 0);
		rq(0, 2, PI, 16'h081e, 4, 0, 16'h081e, 1, 16'h0802);
		rq(0, 2, RD, 16'h0802, 4, 0, 16'h081e, 1, 16'h081e);
		rq(0, 2, RO, 16'h0810, 16'h14, 0, 16'h0804, 0, 0);
		rq(0, 2, RI, 16'h07f0, 4, 0, 16'h0814, 1, 16'h0814);
		rq(0, 3, PI, 16'h081e, 4, 0, 16'h081e, 1, 16'h0822);
		rq(0, 2, IND, 16'h0830, 4, 0, 16'h0830, 0, 0);
		rq(1, 2, PI, 16'h081e, 4, 0, 16'h081e, 1, 16'h0802);
		idle;
		apb(0, `MBAG_OFS_STATUS, 32'h3, 0);
		apb(1, `MBAG_OFS_STATUS, 32'h7, 0);
		apb(0, `MBAG_OFS_STATUS, 32'h0, 0);
		apb(1, `MBAG_OFS_XEND, 32'h0829, 0);
		rq(0, 2, RI, 16'h07f0, 4, 0, 16'h07f4, 1, 16'h07f4);
		rq(0, 2, PI, 16'h0826, 6, 0, 16'h0826, 1, 16'h0802);
		idle;
		apb(1, `MBAG_OFS_CONTROL, 32'h80ff, 0);
		rq(0, 15, PI, 16'h081e, 4, 0, 16'h081e, 1, 16'h0822);
		idle;
		apb(1, `MBAG_OFS_YSTART, 32'h0900, 0);
		apb(1, `MBAG_OFS_YEND, 32'h090f, 0);
		apb(1, `MBAG_OFS_CONTROL, 32'h0f5f, 0);
		rq(2, 5, PI, 16'h090e, 2, 0, 16'h090e, 1, 16'h0910);
		idle;
		apb(1, `MBAG_OFS_CONTROL, 32'h4f5f, 0);
		rq(2, 5, PI, 16'h090e, 2, 0, 16'h090e, 1, 16'h0900);
		rq(2, 5, IND, 16'h0903, 0, 0, 16'h0902, 0, 0);
		rq(2, 5, PD, 16'h0900, 2, 0, 16'h0900, 1, 16'h090e);
		idle;
		apb(1, `MBAG_OFS_XSTART, 32'h1000, 0);
		apb(1, `MBAG_OFS_XEND, 32'h100f, 0);
		apb(1, `MBAG_OFS_CONTROL, 32'h86f6, 0);
		apb(1, `MBAG_OFS_BITREV, 32'h8004, 0);
		idle;
		rq(1, 6, PI, 16'h1000, 2, 0, 16'h1000, 1, 16'h1008);
		rq(1, 6, RI, 16'h1008, 2, 0, 16'h1004, 1, 16'h1004);
		rq(1, 6, RI, 16'h100c, 2, 0, 16'h1002, 1, 16'h1002);
		rq(1, 6, PI, 16'h1004, 1, 1, 16'h1004, 1, 16'h1005);
		rq(1, 6, PD, 16'h1008, 2, 0, 16'h1008, 1, 16'h1006);
		rq(0, 6, PI, 16'h100e, 2, 0, 16'h100e, 1, 16'h1000);
		rq(1, 7, PI, 16'h1000, 2, 0, 16'h1000, 1, 16'h1002);
		idle;
		apb(1, `MBAG_OFS_BITREV, 32'h0004, 0);
		rq(1, 6, PI, 16'h100e, 2, 0, 16'h100e, 1, 16'h1000);
		idle;
		for (i = 0; i < 20 && qxr.size() + qxw.size() + qy.size() + aq.size() > 0; i++)
			@(posedge clock);
		if (i >= 20) begin errors++; $display("[FAIL] %0t results missing", $time); end
		// let the checker sample the last results before the run ends
		repeat (2) @(posedge clock);
		finish_test;
	end
endmodule
